// ==== rtl/fphs_pkg.sv ====
package fphs_pkg;

  // ------------------------------------------------------------------
  // Register map, 8-bit data, word per address
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COEF_LO = 4'h1;
  localparam logic [3:0] ADDR_COEF_HI = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // Field positions
  localparam int CTRL_PATH_LSB = 0;
  localparam int CTRL_PHASE_BIT = 2;
  localparam int STAT_PATH_LSB = 0;
  localparam int STAT_PHASE_BIT = 2;
  localparam int STAT_CONTROL_SOURCE_PIN_BIT = 3;
  localparam int STAT_OVF_BIT = 4;

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] COEF_RST = 16'h0000;

  // Coefficient forced while the pins steer the device
  localparam logic [15:0] PIN_COEF = 16'h0332;

  // Modulator stream runs at a quarter of mclk
  localparam int MOD_DIV = 4;
  localparam logic [1:0] MOD_LAST = 2'(MOD_DIV - 1);

  // Unity in the Q16 coefficient arithmetic
  localparam logic [17:0] Q16_ONE = 18'h10000;

  // Filter chain tap
  typedef enum logic [1:0] {
    FPHS_BYPASS = 2'b00,
    FPHS_SINC = 2'b01,
    FPHS_LP = 2'b10,
    FPHS_LPHP = 2'b11
  } fphs_path_t;

endpackage : fphs_pkg

// ==== rtl/fphs_buf2.sv ====
`timescale 1ns/10ps
module fphs_buf2 #(
  parameter int W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  logic [W-1:0] mem_q [2];
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Honest flags; full back-pressures the writer
  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rd_ptr_q];

  // Pointers and fill level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop) rd_ptr_q <= ~rd_ptr_q;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  // Storage has no reset; out_valid guards it
  always_ff @(posedge mclk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end

  buf_bound_a: assert property (@(posedge mclk) disable iff (!nrst)
    cnt_q == 2'h2 |-> !in_ready)
    else $error("buffer accepts while full");

  buf_full_c: cover property (@(posedge mclk) disable iff (!nrst)
    cnt_q == 2'h2 && !out_ready);

endmodule : fphs_buf2

// ==== rtl/fphs_stage.sv ====
// Behaviour
// RL1: Phase selector 0 linear, 1 minimum; from register bit or pin.
// RL2: High-pass is first-order IIR ((2-a)/2)(1-z^-1)/(1-b z^-1), last stage.
// RL3: Feedback b equals (1+(1-a)^2)^2/2, derived from a.
// RL4: Corner set by 16-bit coefficient in two registers, computed by software.
// RL5: In pin mode the coefficient is fixed at 0332h.
// RL6: Enabled high-pass rejects dc and attenuates below the corner.
// RL7: All timing derives from the master clock.
// RL8: Register mode path field: 00 bypass, 01 sinc, 10 lowpass, 11 +highpass.
// RL9: Pin mode: modulator pin 1 bypasses; else highpass pin picks 10 or 11.
// RL10: Modulator stream runs at a quarter of the master clock.
// RL11: High-pass updates once per accepted low-pass sample.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module fphs_stage #(
  parameter int DATA_W = 24
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [fphs_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic control_source_pin,
  input wire logic phase_select_pin,
  input wire logic highpass_enable_pin,
  input wire logic modulator_select_pin,
  output logic phase_select,
  output logic [1:0] filter_path,
  output logic mod_tick,
  input wire logic mod_bit,
  input wire logic sinc_valid,
  output logic sinc_ready,
  input wire logic [DATA_W-1:0] sinc_data,
  input wire logic lp_valid,
  output logic lp_ready,
  input wire logic [DATA_W-1:0] lp_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);
  import fphs_pkg::*;

  localparam int YW = DATA_W + 18;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  wire [3:0] pin_raw = {modulator_select_pin, highpass_enable_pin,
                        phase_select_pin, control_source_pin};
  wire pin_mode = pin_q[0];

  // Three stages; a level counts once the last two agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      // Hold the old level while the stages disagree
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) pin_q[gi] <= 1'b0;
        else if (pin_s2_q[gi] == pin_s3_q[gi]) pin_q[gi] <= pin_s3_q[gi];
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [15:0] coef_reg_q;
  logic ovf_q;
  logic [7:0] rdata_q;
  logic ovf_set;
  wire wr_ctrl = wr_en && (addr == ADDR_CTRL);
  wire wr_lo = wr_en && (addr == ADDR_COEF_LO);
  wire wr_hi = wr_en && (addr == ADDR_COEF_HI);
  wire wr_stat = wr_en && (addr == ADDR_STATUS);
  wire [7:0] stat_word = {3'h0, ovf_q, pin_mode, phase_select, filter_path};
  wire [7:0] rd_mux = (addr == ADDR_CTRL) ? ctrl_q :
                      (addr == ADDR_COEF_LO) ? coef_reg_q[7:0] :
                      (addr == ADDR_COEF_HI) ? coef_reg_q[15:8] :
                      (addr == ADDR_STATUS) ? stat_word : 8'h00;

  // Writes; a new overflow beats a clearing write of one
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      coef_reg_q <= COEF_RST;
      ovf_q <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= {5'h0, wdata[2:0]};
      if (wr_lo) coef_reg_q[7:0] <= wdata; // RL4
      if (wr_hi) coef_reg_q[15:8] <= wdata; // RL4
      if (ovf_set) ovf_q <= 1'b1;
      else if (wr_stat && wdata[STAT_OVF_BIT]) ovf_q <= 1'b0;
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rdata_q <= 8'h00;
    else rdata_q <= rd_en ? rd_mux : 8'h00;
  end
  assign rdata = rdata_q;

  // ------------------------------------------------------------------
  // Effective configuration
  // ------------------------------------------------------------------
  logic phase_q;
  fphs_path_t path_q;
  logic [15:0] coef_q;
  wire [1:0] pin_path = pin_q[3] ? FPHS_BYPASS : // RL9
                        (pin_q[2] ? FPHS_LPHP : FPHS_LP); // RL9
  wire [1:0] reg_path = ctrl_q[CTRL_PATH_LSB +: 2]; // RL8
  wire [1:0] path_d = pin_mode ? pin_path : reg_path;
  wire phase_d = pin_mode ? pin_q[1] : ctrl_q[CTRL_PHASE_BIT]; // RL1
  wire [15:0] coef_d = pin_mode ? PIN_COEF : coef_reg_q; // RL5

  // Registered so mode changes reach the datapath glitch-free
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_q <= 1'b0;
      path_q <= FPHS_BYPASS;
      coef_q <= COEF_RST;
    end else begin
      phase_q <= phase_d;
      path_q <= fphs_path_t'(path_d);
      coef_q <= coef_d;
    end
  end
  assign phase_select = phase_q;
  assign filter_path = path_q;

  // ------------------------------------------------------------------
  // Modulator rate divider
  // ------------------------------------------------------------------
  logic [1:0] mod_cnt_q;

  // One-cycle enable every fourth mclk edge, no second clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) mod_cnt_q <= 2'h0;
    else mod_cnt_q <= 2'(mod_cnt_q + 2'h1); // RL7
  end
  assign mod_tick = (mod_cnt_q == MOD_LAST); // RL10

  // ------------------------------------------------------------------
  // Feedback coefficient, Q16: b = (1 + (1-a)^2)^2 / 2
  // ------------------------------------------------------------------
  logic [17:0] b_q;
  wire [16:0] one_minus_a = 17'(Q16_ONE - {2'h0, coef_q});
  wire [33:0] c_sq = one_minus_a * one_minus_a;
  wire [17:0] s_val = 18'(Q16_ONE + {1'b0, c_sq[32:16]});
  wire [35:0] s_sq = s_val * s_val;
  wire [17:0] k_gain = 18'(Q16_ONE - {3'h0, coef_q[15:1]}); // RL2

  // One cycle behind the coefficient; settled long before a sample
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) b_q <= Q16_ONE;
    else b_q <= s_sq[34:17]; // RL3
  end

  // ------------------------------------------------------------------
  // High-pass datapath, state carried with 16 fraction bits
  // ------------------------------------------------------------------
  logic signed [DATA_W-1:0] x_prev_q;
  logic signed [YW-1:0] y_q;
  logic buf_in_ready;
  wire sel_sinc = (path_q == FPHS_SINC);
  wire sel_lp = (path_q == FPHS_LP) || (path_q == FPHS_LPHP);
  wire hp_on = (path_q == FPHS_LPHP);
  wire hp_fire = hp_on && lp_valid && buf_in_ready; // RL11
  wire signed [DATA_W:0] x_diff = // RL6
    $signed({lp_data[DATA_W-1], lp_data}) -
    $signed({x_prev_q[DATA_W-1], x_prev_q});
  wire signed [DATA_W+18:0] ff_prod = x_diff * $signed(k_gain);
  wire signed [YW+18:0] fb_prod = y_q * $signed({1'b0, b_q});
  wire signed [YW-1:0] y_d = ff_prod[YW-1:0] + fb_prod[YW+15:16]; // RL2
  wire [DATA_W-1:0] hp_word = y_d[DATA_W+15:16];

  // Recursion advances only on an accepted low-pass sample
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      x_prev_q <= '0;
      y_q <= '0;
    end else if (hp_fire) begin
      x_prev_q <= lp_data; // RL11
      y_q <= y_d; // RL11
    end
  end

  // ------------------------------------------------------------------
  // Output selection and buffering
  // ------------------------------------------------------------------
  wire [DATA_W-1:0] mod_word = mod_bit ? {1'b0, {(DATA_W-1){1'b1}}} :
                                         {1'b1, {(DATA_W-1){1'b0}}};
  wire push_mod = (path_q == FPHS_BYPASS) && mod_tick;
  wire push_valid = push_mod || (sel_sinc && sinc_valid) ||
                    (sel_lp && lp_valid);
  wire [DATA_W-1:0] push_data = (path_q == FPHS_BYPASS) ? mod_word :
                                sel_sinc ? sinc_data :
                                hp_on ? hp_word : lp_data; // RL2
  // Unselected streams are drained so upstream never hangs
  assign sinc_ready = sel_sinc ? buf_in_ready : 1'b1;
  assign lp_ready = sel_lp ? buf_in_ready : 1'b1;
  // The modulator stream cannot stall, so a full buffer drops it
  assign ovf_set = push_mod && !buf_in_ready;

  fphs_buf2 #(.W(DATA_W)) u_buf (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(buf_in_ready),
    .in_data(push_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  phase_source_a: assert property ( // RL1
    ##1 phase_select == $past(pin_mode ? pin_q[1] : ctrl_q[CTRL_PHASE_BIT]))
    else $error("phase select does not follow its source");

  path_reg_a: assert property ( // RL8
    !pin_mode |=> filter_path == $past(ctrl_q[1:0]))
    else $error("register path field not applied");

  path_pin_a: assert property ( // RL9
    pin_mode && pin_q[3] |=> filter_path == FPHS_BYPASS)
    else $error("modulator pin does not force bypass");

  coef_fixed_a: assert property ( // RL5
    pin_mode [*2] |-> coef_q == PIN_COEF)
    else $error("pin mode coefficient not fixed");

  feedback_b_a: assert property ( // RL3
    coef_q == 16'h0000 [*2] |-> b_q == 18'h20000)
    else $error("feedback coefficient wrong for a of zero");

  dc_block_a: assert property ( // RL6
    hp_fire && x_diff == '0 && y_q == '0 |=> y_q == '0)
    else $error("dc leaks through high-pass");

  hp_once_a: assert property ( // RL11
    !hp_fire |=> $stable(y_q) && $stable(x_prev_q))
    else $error("high-pass state moved without a sample");

  mod_rate_a: assert property ( // RL10
    mod_tick |=> !mod_tick [*3] ##1 mod_tick)
    else $error("modulator enable not every fourth cycle");

  read_late_a: assert property ( // RL4
    rd_en && addr == ADDR_COEF_LO |=> rdata == $past(coef_reg_q[7:0]))
    else $error("coefficient read back wrong");

  hp_path_c: cover property (hp_fire ##1 out_valid);
  bypass_c: cover property (push_mod && buf_in_ready);
  pin_mode_c: cover property (pin_mode && filter_path == FPHS_LPHP);
  overflow_c: cover property (ovf_set);

endmodule : fphs_stage

// ==== dv/fphs_sink.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// Downstream sample sink
// ------------------------------------------------------------
module fphs_sink (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic hold,
  input wire logic jitter,
  output logic out_ready
);
  // Random stalls expose words lost under back pressure
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !hold && (!jitter || 1'($urandom_range(1)));
    end
  end
endmodule : fphs_sink

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb;
  import fphs_pkg::*;
  logic mclk, nrst, wr_en, rd_en, mod_bit, hold, jitter, watch;
  logic control_source_pin, phase_select_pin;
  logic highpass_enable_pin, modulator_select_pin;
  logic phase_select, mod_tick, out_valid, out_ready;
  logic sinc_valid, sinc_ready, lp_valid, lp_ready;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] filter_path;
  logic [23:0] sinc_data, lp_data, out_data;
  logic [23:0] exp_q[$];
  int err_total, check_count;

  fphs_stage #(.DATA_W(24)) DUT (.mclk, .nrst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .control_source_pin, .phase_select_pin,
    .highpass_enable_pin, .modulator_select_pin, .phase_select,
    .filter_path, .mod_tick, .mod_bit, .sinc_valid, .sinc_ready,
    .sinc_data, .lp_valid, .lp_ready, .lp_data, .out_valid, .out_ready,
    .out_data);
  fphs_sink sink (.mclk, .nrst, .hold, .jitter, .out_ready);

  // ------------------------------------------------------------
  // Clock, modulator bits, output watcher
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Random modulator bits keep the bypass path busy
  always @(posedge mclk) mod_bit <= 1'($urandom);

  // Each delivered word takes the oldest note off the queue
  always @(posedge mclk) begin
    if (watch && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra word", ~out_data, out_data);
      else chk("out_data", exp_q.pop_front(), out_data);
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] e, g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic do_reset();
    watch = 1'b0;
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
  endtask : do_reset

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask : rd

  // Both streams offered; only the selected one may reach the output
  task automatic send(input logic lp, input logic [23:0] d, e);
    int i;
    lp_valid <= 1'b1;
    sinc_valid <= 1'b1;
    lp_data <= lp ? d : ~d;
    sinc_data <= lp ? ~d : d;
    for (i = 0; i < 200; i++) begin
      @(posedge mclk);
      if (lp ? lp_ready : sinc_ready) break;
    end
    if (i == 200) begin
      chk("input wait", 24'h0, 24'h1);
      finish_test();
    end
    exp_q.push_back(e);
  endtask : send

  task automatic settle(input logic [1:0] path);
    lp_valid <= 1'b0;
    sinc_valid <= 1'b0;
    repeat (60) if (exp_q.size() != 0) @(posedge mclk);
    chk("queue left", 24'h0, 24'(exp_q.size()));
    if (exp_q.size() != 0) finish_test();
    watch = 1'b0;
    repeat (10) @(posedge mclk);
    // Stale bypass words from before the path change drain unchecked
    repeat (40) if (out_valid) @(posedge mclk);
    chk("stale words", 24'h0, 24'(out_valid));
    chk("path", 24'(path), 24'(filter_path));
    watch = 1'b1;
  endtask : settle

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] v;
    logic [3:0] i;
    logic [23:0] r;
    int k;
    void'($urandom(32'h1e02));
    {nrst, wr_en, rd_en, hold, jitter, watch, mod_bit} = '0;
    {control_source_pin, phase_select_pin} = '0;
    {highpass_enable_pin, modulator_select_pin} = '0;
    {addr, wdata, sinc_valid, lp_valid, sinc_data, lp_data} = '0;
    do_reset();
    rd(ADDR_CTRL, v);
    chk("ctrl reset", 24'(CTRL_RST), 24'(v));
    rd(4'h9, v);
    chk("unmapped", 24'h0, 24'(v));
    // Stalled sink in bypass: dropped modulator words flag overflow
    hold <= 1'b1;
    repeat (24) @(posedge mclk);
    rd(ADDR_STATUS, v);
    chk("overflow", 24'h1, 24'(v[STAT_OVF_BIT]));
    hold <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(ADDR_STATUS, 8'h10);
    rd(ADDR_STATUS, v);
    chk("ovf clear", 24'h0, 24'(v[STAT_OVF_BIT]));
    // Every path code and phase, register mode
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, {5'h0, i[2:0]});
      repeat (3) @(posedge mclk);
      chk("reg path", 24'(i[1:0]), 24'(filter_path));
      chk("reg phase", 24'(i[2]), 24'(phase_select));
      rd(ADDR_STATUS, v);
      chk("status", 24'(i[2:0]), 24'(v[3:0]));
    end
    // Modulator stream ticks once per four clocks
    k = 0;
    repeat (40) begin
      @(posedge mclk);
      k += int'(mod_tick === 1'b1);
    end
    chk("ticks", 24'd10, 24'(k));
    // Pin mode: modulator pin wins, then high-pass pin
    control_source_pin <= 1'b1;
    for (i = 0; i < 4; i++) begin
      modulator_select_pin <= i[1];
      highpass_enable_pin <= i[0];
      phase_select_pin <= i[0];
      repeat (8) @(posedge mclk);
      chk("pin path", i[1] ? 24'h0 : {22'h0, 1'b1, i[0]}, 24'(filter_path));
      chk("pin phase", 24'(i[0]), 24'(phase_select));
    end
    control_source_pin <= 1'b0;
    // Low-pass and sinc words pass one for one under random stalls
    jitter <= 1'b1;
    wr(ADDR_CTRL, 8'h02);
    settle(2'b10);
    repeat (6) begin
      r = 24'($urandom);
      send(1'b1, r, r);
    end
    settle(2'b10);
    for (k = 0; k < 6; k++) begin
      r = 24'($urandom);
      send(1'b1, r, r);
    end
    settle(2'b10);
    wr(ADDR_CTRL, 8'h01);
    settle(2'b01);
    repeat (3) begin
      r = 24'($urandom);
      send(1'b0, r, r);
    end
    // A stalled sink lets exactly two words in
    settle(2'b01);
    hold <= 1'b1;
    sinc_valid <= 1'b1;
    k = 0;
    repeat (12) begin
      @(posedge mclk);
      if (sinc_ready) begin
        exp_q.push_back(sinc_data);
        k++;
        sinc_data <= 24'($urandom);
      end
    end
    chk("accepted", 24'd2, 24'(k));
    hold <= 1'b0;
    settle(2'b01);
    // Programmed coefficient 8000h: first output is 0.75 of input
    do_reset();
    wr(ADDR_COEF_LO, 8'h00);
    wr(ADDR_COEF_HI, 8'h80);
    wr(ADDR_CTRL, 8'h03);
    rd(ADDR_COEF_LO, v);
    chk("coef lo", 24'h0, 24'(v));
    rd(ADDR_COEF_HI, v);
    chk("coef hi", 24'h80, 24'(v));
    settle(2'b11);
    send(1'b1, 24'h010000, 24'h00c000);
    settle(2'b11);
    // Pin mode ignores the registers and uses 0332h
    do_reset();
    wr(ADDR_COEF_HI, 8'h80);
    control_source_pin <= 1'b1;
    modulator_select_pin <= 1'b0;
    highpass_enable_pin <= 1'b1;
    settle(2'b11);
    send(1'b1, 24'h000000, 24'h000000);
    send(1'b1, 24'h010000, 24'h00fe67);
    settle(2'b11);
    finish_test();
  end
endmodule : tb
